// ---- interval_timer_pkg.sv ----
// Shared constants and types for the two-channel compare-match interval timer.
// Assumes a 32-bit Avalon-MM slave port with byte addressing, one word per register.

package interval_timer_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 2;
  localparam int REG_W = 16;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 5;
  localparam int IDX_W = 3;
  localparam int PRESCALE_W = 9;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_RUN = 3'h0;
  localparam logic [IDX_W-1:0] IDX_CSR0 = 3'h1;
  localparam logic [IDX_W-1:0] IDX_CNT0 = 3'h2;
  localparam logic [IDX_W-1:0] IDX_PER0 = 3'h3;
  localparam logic [IDX_W-1:0] IDX_CH_STRIDE = 3'h3;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] CSR_RESET = 16'h0000;
  localparam logic [REG_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [REG_W-1:0] PER_RESET = 16'hFFFF;
  localparam logic [NUM_CH-1:0] RUN_RESET = 2'h0;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 9'h000;

  // ----------------------------------------------------------------
  // Rate select codes: divide by 8, 32, 128, 512
  // ----------------------------------------------------------------
  localparam logic [RATE_W-1:0] RATE_DIV8 = 2'h0;
  localparam logic [RATE_W-1:0] RATE_DIV32 = 2'h1;
  localparam logic [RATE_W-1:0] RATE_DIV128 = 2'h2;
  localparam logic [RATE_W-1:0] RATE_DIV512 = 2'h3;
  localparam int DIV8_BITS = 3;
  localparam int DIV32_BITS = 5;
  localparam int DIV128_BITS = 7;
  localparam int DIV512_BITS = 9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_phase_e;

  typedef struct packed {
    logic match_flag;
    logic match_irq_enable;
    logic [RATE_W-1:0] rate_sel;
  } csr_s;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic rd;
    logic wr;
    logic [REG_W-1:0] wdata;
    logic [1:0] be;
  } reg_access_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [IDX_W-1:0] ch_idx(input logic [IDX_W-1:0] base, input int ch);
    ch_idx = base + (ch[0] ? IDX_CH_STRIDE : 3'h0);
  endfunction

  function automatic logic [REG_W-1:0] csr_word(input csr_s c);
    csr_word = CSR_RESET;
    csr_word[FLAG_BIT] = c.match_flag;
    csr_word[IRQ_EN_BIT] = c.match_irq_enable;
    csr_word[RATE_LSB +: RATE_W] = c.rate_sel;
  endfunction

  function automatic logic [REG_W-1:0] merge_bytes(input logic [REG_W-1:0] old_val,
                                                   input logic [REG_W-1:0] new_val,
                                                   input logic [1:0] be);
    merge_bytes = old_val;
    if (be[0]) begin
      merge_bytes[7:0] = new_val[7:0];
    end
    if (be[1]) begin
      merge_bytes[15:8] = new_val[15:8];
    end
  endfunction

endpackage

// ---- interval_timer.sv ----
// Two-channel 16-bit compare-match interval timer with an Avalon-MM register port.
// Assumes standby and manual reset arrive as levels synchronous to core_clk,
// and transfer-controller clear strobes are one-cycle pulses on core_clk.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.

module interval_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Low-power and reset modes
  input wire logic standby,
  input wire logic manual_reset,
  // Avalon-MM slave
  input wire logic [interval_timer_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [interval_timer_pkg::BUS_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [interval_timer_pkg::BUS_W-1:0] readdata,
  output logic waitrequest,
  // Transfer controller flag clear strobes
  input wire logic [interval_timer_pkg::NUM_CH-1:0] xfer_clear,
  // Interrupt requests
  output logic [interval_timer_pkg::NUM_CH-1:0] match_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  interval_timer_pkg::bus_phase_e phase;
  interval_timer_pkg::bus_phase_e next_phase;
  logic [interval_timer_pkg::PRESCALE_W-1:0] prescale;
  logic [interval_timer_pkg::NUM_CH-1:0] run;
  logic [interval_timer_pkg::NUM_CH-1:0] next_run;
  interval_timer_pkg::csr_s csr [interval_timer_pkg::NUM_CH];
  interval_timer_pkg::csr_s next_csr [interval_timer_pkg::NUM_CH];
  logic [interval_timer_pkg::REG_W-1:0] counter [interval_timer_pkg::NUM_CH];
  logic [interval_timer_pkg::REG_W-1:0] next_counter [interval_timer_pkg::NUM_CH];
  logic [interval_timer_pkg::REG_W-1:0] period [interval_timer_pkg::NUM_CH];
  logic [interval_timer_pkg::REG_W-1:0] next_period [interval_timer_pkg::NUM_CH];
  logic [interval_timer_pkg::NUM_CH-1:0] flag_seen;
  logic [interval_timer_pkg::NUM_CH-1:0] next_flag_seen;
  logic [interval_timer_pkg::NUM_CH-1:0] match;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic req = read | write;
  wire logic accept = req & (phase == interval_timer_pkg::BUS_ANSWER);
  wire logic capture = read & (phase == interval_timer_pkg::BUS_IDLE);
  interval_timer_pkg::reg_access_s acc;
  assign acc.idx = address[interval_timer_pkg::IDX_LSB +: interval_timer_pkg::IDX_W];
  assign acc.rd = capture;
  assign acc.wr = write & accept;
  assign acc.wdata = writedata[interval_timer_pkg::REG_W-1:0];
  assign acc.be = byteenable[1:0];

  wire logic wr_run = acc.wr & (acc.idx == interval_timer_pkg::IDX_RUN) & acc.be[0];

  // One wait state: request is answered at the second edge
  assign waitrequest = req & (phase == interval_timer_pkg::BUS_IDLE);
  assign next_phase = (req && phase == interval_timer_pkg::BUS_IDLE) ?
                      interval_timer_pkg::BUS_ANSWER : interval_timer_pkg::BUS_IDLE;

  // ----------------------------------------------------------------
  // Prescaler tick pulses
  // ----------------------------------------------------------------
  logic [3:0] rate_tick;
  assign rate_tick[0] = &prescale[interval_timer_pkg::DIV8_BITS-1:0];
  assign rate_tick[1] = &prescale[interval_timer_pkg::DIV32_BITS-1:0];
  assign rate_tick[2] = &prescale[interval_timer_pkg::DIV128_BITS-1:0];
  assign rate_tick[3] = &prescale[interval_timer_pkg::DIV512_BITS-1:0];

  function automatic logic pick_tick(input logic [3:0] ticks,
                                     input logic [interval_timer_pkg::RATE_W-1:0] sel);
    case (sel)
      interval_timer_pkg::RATE_DIV8: pick_tick = ticks[0];
      interval_timer_pkg::RATE_DIV32: pick_tick = ticks[1];
      interval_timer_pkg::RATE_DIV128: pick_tick = ticks[2];
      interval_timer_pkg::RATE_DIV512: pick_tick = ticks[3];
      default: pick_tick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Run register
  // ----------------------------------------------------------------
  assign next_run = wr_run ? acc.wdata[interval_timer_pkg::NUM_CH-1:0] : run;

  // ----------------------------------------------------------------
  // Channel next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    for (int ch = 0; ch < interval_timer_pkg::NUM_CH; ch++) begin
      logic tick;
      logic wr_csr;
      logic wr_cnt;
      logic wr_per;
      logic rd_csr;
      logic clr_cpu;
      tick = 1'b0;
      wr_csr = 1'b0;
      wr_cnt = 1'b0;
      wr_per = 1'b0;
      rd_csr = 1'b0;
      clr_cpu = 1'b0;
      tick = pick_tick(rate_tick, csr[ch].rate_sel) & run[ch];
      wr_csr = acc.wr & acc.be[0] & (acc.idx == interval_timer_pkg::ch_idx(
               interval_timer_pkg::IDX_CSR0, ch));
      wr_cnt = acc.wr & (|acc.be) & (acc.idx == interval_timer_pkg::ch_idx(
               interval_timer_pkg::IDX_CNT0, ch));
      wr_per = acc.wr & (|acc.be) & (acc.idx == interval_timer_pkg::ch_idx(
               interval_timer_pkg::IDX_PER0, ch));
      rd_csr = acc.rd & (acc.idx == interval_timer_pkg::ch_idx(
               interval_timer_pkg::IDX_CSR0, ch));

      // Equality is acted on only at the next counter tick
      match[ch] = tick & (counter[ch] == period[ch]);

      // Counter: match clear, then write, then increment
      if (match[ch]) begin
        next_counter[ch] = interval_timer_pkg::CNT_RESET;
      end else if (wr_cnt) begin
        next_counter[ch] = interval_timer_pkg::merge_bytes(counter[ch], acc.wdata,
                                                           acc.be);
      end else if (tick) begin
        next_counter[ch] = counter[ch] + 16'h0001;
      end else begin
        next_counter[ch] = counter[ch];
      end

      next_period[ch] = wr_per ?
        interval_timer_pkg::merge_bytes(period[ch], acc.wdata, acc.be) : period[ch];

      // Flag: software writes can only clear it; a new match wins over any clear
      clr_cpu = wr_csr & ~acc.wdata[interval_timer_pkg::FLAG_BIT] & flag_seen[ch];
      next_csr[ch] = csr[ch];
      next_csr[ch].match_flag = match[ch] |
        (csr[ch].match_flag & ~(clr_cpu | xfer_clear[ch]));
      if (wr_csr) begin
        next_csr[ch].match_irq_enable = acc.wdata[interval_timer_pkg::IRQ_EN_BIT];
        next_csr[ch].rate_sel =
          acc.wdata[interval_timer_pkg::RATE_LSB +: interval_timer_pkg::RATE_W];
      end

      // Arm the clear when a one is read; a fresh match disarms it
      if (match[ch] || wr_csr || xfer_clear[ch]) begin
        next_flag_seen[ch] = 1'b0;
      end else if (rd_csr) begin
        next_flag_seen[ch] = csr[ch].match_flag;
      end else begin
        next_flag_seen[ch] = flag_seen[ch];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [interval_timer_pkg::REG_W-1:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (acc.idx == interval_timer_pkg::IDX_RUN) begin
      rd_word = {14'h0000, run};
    end
    for (int ch = 0; ch < interval_timer_pkg::NUM_CH; ch++) begin
      if (acc.idx == interval_timer_pkg::ch_idx(interval_timer_pkg::IDX_CSR0, ch)) begin
        rd_word = interval_timer_pkg::csr_word(csr[ch]);
      end
      if (acc.idx == interval_timer_pkg::ch_idx(interval_timer_pkg::IDX_CNT0, ch)) begin
        rd_word = counter[ch];
      end
      if (acc.idx == interval_timer_pkg::ch_idx(interval_timer_pkg::IDX_PER0, ch)) begin
        rd_word = period[ch];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int ch = 0; ch < interval_timer_pkg::NUM_CH; ch++) begin
      match_irq[ch] = csr[ch].match_flag & csr[ch].match_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // Bus phase and read data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase <= interval_timer_pkg::BUS_IDLE;
      readdata <= 32'h0000_0000;
    end else begin
      phase <= next_phase;
      if (capture) begin
        readdata <= {16'h0000, rd_word};
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and run bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescale <= interval_timer_pkg::PRESCALE_RESET;
      run <= interval_timer_pkg::RUN_RESET;
    end else if (standby || manual_reset) begin
      prescale <= interval_timer_pkg::PRESCALE_RESET;
      run <= interval_timer_pkg::RUN_RESET;
    end else begin
      prescale <= prescale + 9'h001;
      run <= next_run;
    end
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    for (int ch = 0; ch < interval_timer_pkg::NUM_CH; ch++) begin
      if (rst) begin
        csr[ch] <= '0;
        counter[ch] <= interval_timer_pkg::CNT_RESET;
        period[ch] <= interval_timer_pkg::PER_RESET;
        flag_seen[ch] <= 1'b0;
      end else if (standby) begin
        csr[ch] <= '0;
        counter[ch] <= interval_timer_pkg::CNT_RESET;
        period[ch] <= interval_timer_pkg::PER_RESET;
        flag_seen[ch] <= 1'b0;
      end else if (manual_reset) begin
        csr[ch] <= '0;
        counter[ch] <= interval_timer_pkg::CNT_RESET;
        flag_seen[ch] <= 1'b0;
      end else begin
        csr[ch] <= next_csr[ch];
        counter[ch] <= next_counter[ch];
        period[ch] <= next_period[ch];
        flag_seen[ch] <= next_flag_seen[ch];
      end
    end
  end

endmodule

// ---- interval_timer_chk.sv ----
// Port-level checker for the two-channel interval timer.
// Assumes the register map and one-wait-state bus timing of the timer's package.

module interval_timer_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Mode inputs
  input wire logic standby,
  input wire logic manual_reset,
  // Register bus
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Flag clears and requests
  input wire logic [1:0] xfer_clear,
  input wire logic [1:0] match_irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire logic [2:0] idx = address[4:2];
  wire logic rd_done = read && !waitrequest;
  wire logic csr_wr0 = write && !waitrequest && idx == 3'h1 && byteenable[0];
  wire logic csr_wr1 = write && !waitrequest && idx == 3'h4 && byteenable[0];
  wire logic drop0 = write || xfer_clear[0] || standby || manual_reset;
  wire logic drop1 = write || xfer_clear[1] || standby || manual_reset;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request waited more than one cycle");
  a_wait_first: assert property ($rose(read) || $rose(write) |-> waitrequest)
    else $error("request answered without a wait state");
  a_rd_upper: assert property (rd_done |-> readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_csr_rsvd: assert property (rd_done && (idx == 3'h1 || idx == 3'h4) |->
    readdata[15:8] == 8'h00 && readdata[5:2] == 4'h0)
    else $error("reserved status bits not zero");
  a_run_rsvd: assert property (rd_done && idx == 3'h0 |-> readdata[15:2] == 14'h0000)
    else $error("reserved run bits not zero");
  a_gap_zero: assert property (rd_done && idx == 3'h7 |-> readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_irq_off0: assert property (csr_wr0 && !writedata[6] |=> !match_irq[0])
    else $error("channel 0 request while disabled");
  a_irq_off1: assert property (csr_wr1 && !writedata[6] |=> !match_irq[1])
    else $error("channel 1 request while disabled");
  a_irq_fall0: assert property ($fell(match_irq[0]) |-> $past(drop0))
    else $error("channel 0 request dropped without cause");
  a_irq_fall1: assert property ($fell(match_irq[1]) |-> $past(drop1))
    else $error("channel 1 request dropped without cause");
  a_stby_quiet: assert property (standby |=> match_irq == 2'h0)
    else $error("request survived standby");
endmodule

bind interval_timer interval_timer_chk i_chk (.core_clk(core_clk), .rst(rst),
  .standby(standby), .manual_reset(manual_reset), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .xfer_clear(xfer_clear), .match_irq(match_irq));

// ---- xfer_model.sv ----
// Transfer-controller model: answers a raised request with one clear strobe.
// Assumes requests are levels that fall the cycle after the strobe lands.

module xfer_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bench control
  input wire logic [1:0] enable,
  input wire logic slow,
  // Timer side
  input wire logic [1:0] match_irq,
  output logic [1:0] xfer_clear
);
  logic [1:0] pend;

  // Slow mode answers one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend <= 2'h0;
      xfer_clear <= 2'h0;
    end else begin
      pend <= enable & match_irq & ~xfer_clear;
      xfer_clear <= (slow ? pend : enable) & match_irq & ~xfer_clear;
    end
  end
endmodule

// ---- interval_timer_test.sv ----
// Self-checking bench for the interval timer over its register bus.
// Assumes the timer's register map and the transfer-controller model.

module interval_timer_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  logic manual_reset = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] xfer_clear;
  logic [1:0] match_irq;
  logic [1:0] xfer_on = 2'h0;
  logic slow = 1'b0;
  int err_total = 0;
  int check_count = 0;

  always #2.5 core_clk = ~core_clk;

  interval_timer i_dut (.core_clk(core_clk), .rst(rst), .standby(standby),
    .manual_reset(manual_reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .xfer_clear(xfer_clear), .match_irq(match_irq));
  xfer_model i_xfer (.core_clk(core_clk), .rst(rst), .enable(xfer_on), .slow(slow),
    .match_irq(match_irq), .xfer_clear(xfer_clear));

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input logic [2:0] i, input logic [15:0] d,
                     input logic [1:0] be, output logic [15:0] q);
    @(posedge core_clk);
    address <= {i, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {16'h0000, d};
    byteenable <= {2'b00, be};
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    q = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] i, input logic [15:0] d, input logic [1:0] be = 2'h3);
    logic [15:0] q;
    acc(1'b1, i, d, be, q);
  endtask

  task automatic rdc(input logic [2:0] i, input logic [15:0] e, input string nm);
    logic [15:0] q;
    acc(1'b0, i, 16'h0000, 2'h3, q);
    chk({16'h0000, q}, {16'h0000, e}, nm);
  endtask

  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (xfer_clear[0] !== 1'b1 && n < 5000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] exp [8] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF,
                             16'h0000, 16'h0000, 16'hFFFF, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      rdc(3'(i), exp[i], "reset value");
    end
    $display("reset values done");
  endtask

  task automatic t_counter;
    wr(3'h2, 16'h1234);
    rdc(3'h2, 16'h1234, "counter word");
    wr(3'h2, 16'hAB00, 2'h2);
    rdc(3'h2, 16'hAB34, "counter byte");
    wr(3'h2, 16'h0000);
    $display("counter access done");
  endtask

  task automatic t_flag;
    wr(3'h6, 16'h0001);
    wr(3'h4, 16'h00C0);
    rdc(3'h4, 16'h0040, "flag write one");
    wr(3'h0, 16'h0002);
    repeat (40) @(posedge core_clk);
    wr(3'h0, 16'h0000);
    chk({30'h0, match_irq}, 32'h2, "irq lines");
    wr(3'h4, 16'h0040);
    rdc(3'h4, 16'h00C0, "clear unread");
    wr(3'h4, 16'h0040);
    rdc(3'h4, 16'h0040, "clear after read");
    chk({30'h0, match_irq}, 32'h0, "irq cleared");
    $display("flag handling done");
  endtask

  task automatic t_rates;
    int n;
    wr(3'h3, 16'h0002);
    xfer_on <= 2'h1;
    for (int r = 0; r < 4; r++) begin
      slow <= r[0];
      wr(3'h1, {14'h0010, r[1:0]});
      wr(3'h0, 16'h0001);
      wait_pulse(n);
      wait_pulse(n);
      chk(32'(n), 32'(3 << (3 + 2 * r)), "match interval");
      wr(3'h0, 16'h0000);
    end
    xfer_on <= 2'h0;
    $display("rates done");
  endtask

  // Channel 0 at divide by 8, period 2: ticks fall 8, 16, 24 cycles after a match
  task automatic t_clash;
    int n;
    slow <= 1'b0;
    xfer_on <= 2'h1;
    wr(3'h1, 16'h0040);
    wr(3'h3, 16'h0002);
    wr(3'h0, 16'h0001);
    wait_pulse(n);
    repeat (19) @(posedge core_clk);
    wr(3'h2, 16'h0100);
    rdc(3'h2, 16'h0000, "match beats write");
    repeat (2) @(posedge core_clk);
    wr(3'h2, 16'h0100);
    rdc(3'h2, 16'h0100, "write beats tick");
    wr(3'h0, 16'h0000);
    xfer_on <= 2'h0;
    $display("contention done");
  endtask

  task automatic t_modes;
    wr(3'h6, 16'h0055);
    wr(3'h4, 16'h0041);
    wr(3'h5, 16'h0007);
    @(posedge core_clk);
    manual_reset <= 1'b1;
    @(posedge core_clk);
    manual_reset <= 1'b0;
    rdc(3'h6, 16'h0055, "period kept");
    rdc(3'h4, 16'h0000, "status manual");
    rdc(3'h5, 16'h0000, "counter manual");
    wr(3'h5, 16'h0009);
    wr(3'h4, 16'h0042);
    @(posedge core_clk);
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    rdc(3'h6, 16'hFFFF, "period standby");
    rdc(3'h5, 16'h0000, "counter standby");
    rdc(3'h4, 16'h0000, "status standby");
    $display("modes done");
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_counter();
    t_flag();
    t_rates();
    t_clash();
    t_modes();
    test_done();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    test_done();
  end
endmodule
